// ### hw/fspwg_host.v
// The implementer's own choices: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ns
`include "fspwg_map.vh"

module fspwg_host #(
	parameter ADDR_W = 22,
	parameter CNT_W  = 8
) (
	input  wire              ref_clk,
	input  wire              reset_n,
	input  wire [3:0]        wb_adr_i,
	input  wire [31:0]       wb_dat_i,
	output reg  [31:0]       wb_dat_o,
	input  wire              wb_we_i,
	input  wire [3:0]        wb_sel_i,
	input  wire              wb_cyc_i,
	input  wire              wb_stb_i,
	output reg               wb_ack_o,
	output reg  [ADDR_W-1:0] flashAddr,
	input  wire [15:0]       flashDataIn,
	output reg  [15:0]       flashDataOut,
	output reg               flashDataOe,
	output reg               chipStrobe_n,
	output reg               writeStrobe_n,
	output reg               outputStrobe_n,
	output reg               widthSelect,
	output reg               flashReset_n,
	input  wire              readyBusyIn
);

	// ****************************************
	// states
	// ****************************************
	localparam [8:0] ST_IDLE  = 9'b0_0000_0001;
	localparam [8:0] ST_RDLO  = 9'b0_0000_0010;
	localparam [8:0] ST_RDHI  = 9'b0_0000_0100;
	localparam [8:0] ST_WRLO  = 9'b0_0000_1000;
	localparam [8:0] ST_WRHI  = 9'b0_0001_0000;
	localparam [8:0] ST_EVAL  = 9'b0_0010_0000;
	localparam [8:0] ST_HRST  = 9'b0_0100_0000;
	localparam [8:0] ST_ARRAY = 9'b0_1000_0000;
	localparam [8:0] ST_NEXT  = 9'b1_0000_0000;

	// counts are worked out as integers, then cut to the counter width on purpose
	localparam integer     PULSE_I = `FSPWG_PULSE_CYC;
	localparam integer     RECOV_I = `FSPWG_RECOV_CYC;
	localparam [CNT_W-1:0] PULSE   = PULSE_I[CNT_W-1:0];
	localparam [CNT_W-1:0] RECOV   = RECOV_I[CNT_W-1:0];

	// poll phases
	localparam [1:0] PH_FIRST = 2'd0;
	localparam [1:0] PH_SECND = 2'd1;
	localparam [1:0] PH_RECHK = 2'd2;

	reg [8:0]        state;
	reg [CNT_W-1:0]  cnt;
	reg [1:0]        cmd;
	reg [1:0]        phase;
	reg [1:0]        seqIdx;
	reg [15:0]       rdData;
	reg [15:0]       wrData;
	reg [ADDR_W-1:0] regAddr;
	reg              firstToggle;
	reg              busy;
	reg              done;
	reg              failed;
	reg              aborted;
	reg [2:0]        rbSync;
	reg              readyPin;
	reg [15:0]       dataQ1;
	reg [15:0]       dataQ2;
	reg [15:0]       dataQ3;
	reg [15:0]       dataIn;
	reg              arrayRd;

	// ****************************************
	// helpers
	// ****************************************
	function toggleOf;
		input [15:0] d;
		begin
			toggleOf = d[`FSPWG_BIT_TOGGLE];
		end
	endfunction

	// ready/busy pin: three stages, change taken when last two agree
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			rbSync   <= 3'b111;
			readyPin <= 1'b1;
		end else begin
			rbSync <= {rbSync[1:0], readyBusyIn};
			if (rbSync[1] == rbSync[2])
				readyPin <= rbSync[2];
		end
	end

	// data lines: three stages, word taken once the last two agree,
	// so a line caught mid-change never reaches the toggle compare
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			dataQ1 <= 16'h0000;
			dataQ2 <= 16'h0000;
			dataQ3 <= 16'h0000;
			dataIn <= 16'h0000;
		end else begin
			dataQ1 <= flashDataIn;
			dataQ2 <= dataQ1;
			dataQ3 <= dataQ2;
			if (dataQ2 == dataQ3)
				dataIn <= dataQ3;
		end
	end

	// ****************************************
	// wishbone slave
	// ****************************************
	// ack one cycle after strobe, dropped the cycle after
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			wb_ack_o    <= 1'b0;
			wb_dat_o    <= `FSPWG_RESET_VAL;
			cmd         <= `FSPWG_CMD_POLL;
			widthSelect <= 1'b1;
			regAddr     <= {ADDR_W{1'b0}};
			wrData      <= 16'h0000;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
			if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
				wb_dat_o <= 32'h0000_0000;
				case (wb_adr_i)
				`FSPWG_REG_CTRL: begin
					wb_dat_o[`FSPWG_CTRL_CMD_HI:`FSPWG_CTRL_CMD_LO] <= cmd;
					wb_dat_o[`FSPWG_CTRL_WORD] <= widthSelect;
					if (wb_we_i && wb_sel_i[0] && !busy) begin
						cmd <= wb_dat_i[`FSPWG_CTRL_CMD_HI:`FSPWG_CTRL_CMD_LO];
						widthSelect <= wb_dat_i[`FSPWG_CTRL_WORD];
					end
				end
				`FSPWG_REG_STATUS: begin
					wb_dat_o[`FSPWG_ST_BUSY]   <= busy;
					wb_dat_o[`FSPWG_ST_DONE]   <= done;
					wb_dat_o[`FSPWG_ST_FAIL]   <= failed;
					wb_dat_o[`FSPWG_ST_ABORT]  <= aborted;
					wb_dat_o[`FSPWG_ST_RDYPIN] <= readyPin;
				end
				`FSPWG_REG_ADDR: begin
					wb_dat_o[ADDR_W-1:0] <= regAddr;
					if (wb_we_i && !busy)
						regAddr <= wb_dat_i[ADDR_W-1:0];
				end
				`FSPWG_REG_DATA: begin
					wb_dat_o[15:0] <= rdData;
					if (wb_we_i && !busy)
						wrData <= wb_dat_i[15:0];
				end
				default: wb_dat_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	wire startReq = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && !busy
		&& (wb_adr_i == `FSPWG_REG_CTRL) && wb_dat_i[`FSPWG_CTRL_START];

	// ****************************************
	// flash sequencer
	// ****************************************
	// one-hot machine; reads use the output strobe so each read is a fresh toggle sample
	always @(posedge ref_clk) begin
		if (!reset_n) begin
			state          <= ST_IDLE;
			cnt            <= {CNT_W{1'b0}};
			phase          <= PH_FIRST;
			seqIdx         <= 2'd0;
			busy           <= 1'b0;
			done           <= 1'b0;
			failed         <= 1'b0;
			aborted        <= 1'b0;
			firstToggle    <= 1'b0;
			arrayRd        <= 1'b0;
			rdData         <= 16'h0000;
			flashAddr      <= {ADDR_W{1'b0}};
			flashDataOut   <= 16'h0000;
			flashDataOe    <= 1'b0;
			chipStrobe_n   <= 1'b1;
			writeStrobe_n  <= 1'b1;
			outputStrobe_n <= 1'b1;
			flashReset_n   <= 1'b1;
		end else begin
			case (state)
			ST_IDLE: begin
				if (startReq) begin
					busy      <= 1'b1;
					done      <= 1'b0;
					cnt       <= PULSE;
					flashAddr <= regAddr;
					seqIdx    <= 2'd0;
					case (wb_dat_i[`FSPWG_CTRL_CMD_HI:`FSPWG_CTRL_CMD_LO])
					`FSPWG_CMD_POLL: begin
						failed <= 1'b0;
						phase  <= PH_FIRST;
						state  <= ST_RDLO;
					end
					`FSPWG_CMD_READ: begin
						phase <= PH_FIRST;
						state <= ST_ARRAY;
					end
					`FSPWG_CMD_WRITE: begin
						flashDataOut <= wrData;
						state        <= ST_WRLO;
					end
					default: begin
						flashReset_n <= 1'b0;
						state        <= ST_HRST;
					end
					endcase
				end
			end
			ST_RDLO, ST_ARRAY: begin
				// output strobe low only with write strobe high: no write possible
				chipStrobe_n   <= 1'b0;
				outputStrobe_n <= 1'b0;
				flashDataOe    <= 1'b0;
				if (cnt == {CNT_W{1'b0}}) begin
					rdData         <= dataIn;
					outputStrobe_n <= 1'b1;
					chipStrobe_n   <= 1'b1;
					cnt            <= RECOV;
					arrayRd        <= (state == ST_ARRAY);
					state          <= ST_RDHI;
				end else
					cnt <= cnt - 1'b1;
			end
			ST_RDHI: begin
				// array reads get the same recovery before done, so no new access crowds them
				if (cnt == {CNT_W{1'b0}})
					state <= arrayRd ? ST_NEXT : ST_EVAL;
				else
					cnt <= cnt - 1'b1;
			end
			ST_EVAL: begin
				cnt   <= PULSE;
				state <= ST_RDLO;
				if (phase == PH_FIRST) begin
					firstToggle <= toggleOf(rdData);
					phase       <= PH_SECND;
				end else if (toggleOf(rdData) == firstToggle) begin
					// steady toggle: finished, array data valid next read
					phase <= PH_FIRST;
					state <= ST_ARRAY;
				end else if (rdData[`FSPWG_BIT_ABORT]) begin
					aborted <= 1'b1;
					seqIdx  <= 2'd0;
					state   <= ST_WRLO;
				end else if (phase == PH_RECHK) begin
					failed <= 1'b1;
					seqIdx <= 2'd3;
					state  <= ST_WRLO;
				end else if (rdData[`FSPWG_BIT_TIMEOUT]) begin
					firstToggle <= toggleOf(rdData);
					phase       <= PH_RECHK;
				end else begin
					// timeout low: keep polling, restart pairing from this sample
					firstToggle <= toggleOf(rdData);
				end
			end
			ST_WRLO: begin
				// write cycle: chip and write strobe low, output strobe high
				outputStrobe_n <= 1'b1;
				chipStrobe_n   <= 1'b0;
				writeStrobe_n  <= 1'b0;
				flashDataOe    <= 1'b1;
				if (aborted) begin
					// abort-reset: unlock, unlock, reset byte in low lane
					case (seqIdx)
					2'd0: begin
						flashAddr    <= `FSPWG_UNLOCK1_ADDR;
						flashDataOut <= {8'h00, `FSPWG_UNLOCK1_DATA};
					end
					2'd1: begin
						flashAddr    <= `FSPWG_UNLOCK2_ADDR;
						flashDataOut <= {8'h00, `FSPWG_UNLOCK2_DATA};
					end
					default: flashDataOut <= {8'h00, `FSPWG_RESET_DATA};
					endcase
				end else if (failed)
					flashDataOut <= {8'h00, `FSPWG_RESET_DATA};
				if (cnt == {CNT_W{1'b0}}) begin
					writeStrobe_n <= 1'b1;
					chipStrobe_n  <= 1'b1;
					cnt           <= RECOV;
					state         <= ST_WRHI;
				end else
					cnt <= cnt - 1'b1;
			end
			ST_WRHI: begin
				if (cnt == {CNT_W{1'b0}}) begin
					flashDataOe <= 1'b0;
					if (aborted && seqIdx < 2'd2) begin
						seqIdx <= seqIdx + 2'd1;
						cnt    <= PULSE;
						state  <= ST_WRLO;
					end else begin
						aborted <= 1'b0;
						state   <= ST_NEXT;
					end
				end else
					cnt <= cnt - 1'b1;
			end
			ST_HRST: begin
				if (cnt == {CNT_W{1'b0}}) begin
					flashReset_n <= 1'b1;
					state        <= ST_NEXT;
				end else
					cnt <= cnt - 1'b1;
			end
			ST_NEXT: begin
				busy  <= 1'b0;
				done  <= 1'b1;
				state <= ST_IDLE;
			end
			default: state <= ST_IDLE;
			endcase
		end
	end

endmodule

// ### include/fspwg_map.vh
`ifndef FSPWG_MAP_VH
`define FSPWG_MAP_VH

// register offsets (byte addresses)
`define FSPWG_REG_CTRL      4'h0
`define FSPWG_REG_STATUS    4'h4
`define FSPWG_REG_ADDR      4'h8
`define FSPWG_REG_DATA      4'hC

// control field positions
`define FSPWG_CTRL_START    0
`define FSPWG_CTRL_CMD_LO   1
`define FSPWG_CTRL_CMD_HI   2
`define FSPWG_CTRL_WORD     3

// commands in the control register
`define FSPWG_CMD_POLL      2'h0
`define FSPWG_CMD_READ      2'h1
`define FSPWG_CMD_WRITE     2'h2
`define FSPWG_CMD_RESET     2'h3

// status bit positions
`define FSPWG_ST_BUSY       0
`define FSPWG_ST_DONE       1
`define FSPWG_ST_FAIL       2
`define FSPWG_ST_ABORT      3
`define FSPWG_ST_RDYPIN     4

// status bit positions on the flash data lines
`define FSPWG_BIT_TOGGLE    6
`define FSPWG_BIT_TIMEOUT   5
`define FSPWG_BIT_ABORT     1

// flash command data: reset and buffer-abort-reset unlock bytes
`define FSPWG_RESET_DATA    8'hF0
`define FSPWG_UNLOCK1_ADDR  22'h00_0555
`define FSPWG_UNLOCK1_DATA  8'hAA
`define FSPWG_UNLOCK2_ADDR  22'h00_02AA
`define FSPWG_UNLOCK2_DATA  8'h55

// strobe timing in ns and derived cycles at 4 ns
`define FSPWG_CLK_NS        4
`define FSPWG_PULSE_NS      100
`define FSPWG_PULSE_CYC     ((`FSPWG_PULSE_NS + `FSPWG_CLK_NS - 1) / `FSPWG_CLK_NS)
`define FSPWG_RECOV_NS      40
`define FSPWG_RECOV_CYC     ((`FSPWG_RECOV_NS + `FSPWG_CLK_NS - 1) / `FSPWG_CLK_NS)
`define FSPWG_RESET_VAL     32'h0000_0000

`endif

// ### dv/fspwg_host_sva.sv
`timescale 1ns/1ns
module fspwg_host_sva (
	input logic ref_clk,
	input logic reset_n,
	input logic wb_cyc_i,
	input logic wb_stb_i,
	input logic wb_ack_o,
	input logic chipStrobe_n,
	input logic writeStrobe_n,
	input logic outputStrobe_n,
	input logic flashDataOe,
	input logic flashReset_n
);
	// ****
	// bus and strobe checks
	// ****
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [7:0] lowCnt;
	// low time of the read strobe, so the status sample window is known
	always @(posedge ref_clk) begin
		if (!reset_n || outputStrobe_n)
			lowCnt <= 8'h00;
		else
			lowCnt <= lowCnt + 8'h01;
	end
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ack_pulse;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	property p_ack;
		s_req |=> s_ack_pulse;
	endproperty
	property p_idle;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	property p_write_qual;
		!writeStrobe_n |-> !chipStrobe_n && outputStrobe_n && flashDataOe;
	endproperty
	property p_read_qual;
		!outputStrobe_n |-> !chipStrobe_n && writeStrobe_n && !flashDataOe;
	endproperty
	property p_read_len;
		$rose(outputStrobe_n) |-> lowCnt == 8'd25;
	endproperty
	property p_recovery;
		$rose(outputStrobe_n) |-> (outputStrobe_n && writeStrobe_n) [*8];
	endproperty
	property p_write_len;
		$fell(writeStrobe_n) |-> !writeStrobe_n [*8];
	endproperty
	property p_reset_quiet;
		!flashReset_n |-> chipStrobe_n && writeStrobe_n && outputStrobe_n;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
	a_idle: assert property (p_idle) else $error("ack without request");
	a_write_qual: assert property (p_write_qual) else $error("write strobe badly qualified");
	a_read_qual: assert property (p_read_qual) else $error("read strobe badly qualified");
	a_read_len: assert property (p_read_len) else $error("status read pulse length wrong");
	a_recovery: assert property (p_recovery) else $error("no recovery after read");
	a_write_len: assert property (p_write_len) else $error("write pulse too short");
	a_reset_quiet: assert property (p_reset_quiet) else $error("access during flash reset");
endmodule
bind fspwg_host fspwg_host_sva u_fspwg_host_sva (.*);

// ### dv/fspwg_flash.sv
`timescale 1ns/1ns
module fspwg_flash #(
	parameter logic [15:0] ARRAY_WORD = 16'h5A3C
) (
	input  logic        chipStrobe_n,
	input  logic        writeStrobe_n,
	input  logic        outputStrobe_n,
	input  logic [15:0] flashDataOut,
	input  logic        flashReset_n,
	input  logic        widthSelect,
	output logic [15:0] flashDataIn,
	output logic        readyBusyIn
);
	// ****
	// behavioural flash status model
	// ****
	int          busyLeft = 0;
	logic        stuck = 1'b0;
	logic        timeoutOn = 1'b0;
	logic        abortOn = 1'b0;
	logic        toggle = 1'b0;
	logic        wrOk = 1'b0;
	logic [7:0]  wrByte = 8'h00;
	logic [15:0] lastOut = 16'h0000;
	logic [31:0] cmdHist = 32'h0000_0000;
	logic [31:0] resets = 32'h0000_0000;
	logic [15:0] oldHist = 16'h0000;
	logic        eraseToggle = 1'b0;
	logic        erasing = 1'b0;
	logic        suspended = 1'b0;
	logic        suspProgRead = 1'b0;
	logic        lockout = 1'b0;
	logic        protectOn = 1'b0;
	wire         busy = stuck || busyLeft > 0;
	// strobes fall together, so look 1 ns later to avoid a race
	always @(negedge outputStrobe_n) begin
		#1;
		if (!chipStrobe_n && flashReset_n) begin
			if (suspended) begin
				// suspended sector: poll and toggle read 1, erase toggle keeps going
				eraseToggle = ~eraseToggle;
				lastOut = {8'h00, 2'b11, 3'b000, eraseToggle | suspProgRead, 2'b00};
			end else if (busy) begin
				toggle = ~toggle;
				if (erasing)
					eraseToggle = ~eraseToggle;
				lastOut = {8'h00, 1'b0, toggle, timeoutOn, 2'b00, eraseToggle, abortOn, 1'b0};
				if (!stuck)
					busyLeft--;
				if (busyLeft == 0)
					erasing = 1'b0;
			end else begin
				lastOut = widthSelect ? ARRAY_WORD : {~lastOut[15:8], ARRAY_WORD[7:0]};
			end
		end
	end
	// released lines show the inverse, never the last value
	assign flashDataIn = (!chipStrobe_n && !outputStrobe_n) ? lastOut : ~lastOut;
	assign readyBusyIn = flashReset_n && (!busy || suspended);
	always @(negedge writeStrobe_n) begin
		#1;
		wrOk = !chipStrobe_n && outputStrobe_n && flashReset_n && !lockout;
		wrByte = flashDataOut[7:0];
	end
	// commands are taken on the rising write edge
	always @(posedge writeStrobe_n) begin
		if (wrOk) begin
			{oldHist, cmdHist} = {oldHist[7:0], cmdHist, wrByte};
			if (wrByte == 8'hF0) begin
				stuck = 1'b0;
				busyLeft = 0;
				erasing = 1'b0;
				timeoutOn = 1'b0;
				abortOn = 1'b0;
			end else if (!protectOn && cmdHist[31:8] == 24'hAA_55A0) begin
				busyLeft = 3;
			end else if (!protectOn && {oldHist, cmdHist} == 48'hAA55_80AA_5530) begin
				busyLeft = 3;
				erasing = 1'b1;
			end
		end
	end
	// supply lockout drops any running operation back to read mode
	always @(posedge lockout) begin
		busyLeft = 0;
		stuck = 1'b0;
		erasing = 1'b0;
	end
	always @(negedge flashReset_n) begin
		resets = resets + 32'h0000_0001;
		busyLeft = 0;
		stuck = 1'b0;
		erasing = 1'b0;
	end
endmodule

// ### dv/fspwg_host_bench.sv
`timescale 1ns/1ns
`include "fspwg_map.vh"
module fspwg_host_bench;
	// ****
	// stimulus and checking
	// ****
	logic        ref_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [3:0]  wb_adr_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_sel_i = 4'hF;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic        wb_ack_o;
	logic [21:0] flashAddr;
	logic [15:0] flashDataIn;
	logic [15:0] flashDataOut;
	logic        flashDataOe, chipStrobe_n, writeStrobe_n, outputStrobe_n;
	logic        widthSelect, flashReset_n, readyBusyIn;
	logic [31:0] rd;
	int          failCount = 0;
	int          nChecks = 0;
	always #2 ref_clk = ~ref_clk;
	fspwg_host u_fspwg_host (.*);
	fspwg_flash u_fspwg_flash (.*);
	// one classic cycle, held until ack is sampled
	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int n;
		n = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1)
			failCount++;
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) begin
			failCount++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// bounded wait for the operation to finish; leaves status in rd
	task automatic wdone;
		int n;
		n = 0;
		do begin
			wb(1'b0, `FSPWG_REG_STATUS, 32'h0000_0000);
			n++;
		end while (rd[0] !== 1'b0 && n < 500);
		if (rd[0] !== 1'b0)
			failCount++;
	endtask
	// one flash write cycle through DATA and a write command, then wait
	task automatic fwr(input logic [15:0] d);
		wb(1'b1, `FSPWG_REG_DATA, {16'h0000, d});
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_000D);
		wdone;
	endtask
	task automatic complete_run;
		$display("checks=%0d errors=%0d", nChecks, failCount);
		if (failCount == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge ref_clk);
		failCount++;
		complete_run;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset_n <= 1'b1;
		@(posedge ref_clk);
		wb(1'b0, `FSPWG_REG_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0010);
		wb(1'b0, 4'h2, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, `FSPWG_REG_ADDR, 32'h0000_1234);
		u_fspwg_flash.busyLeft <= 4;
		repeat (4) @(posedge ref_clk);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wb(1'b0, `FSPWG_REG_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		wb(1'b1, `FSPWG_REG_ADDR, 32'h0000_0777);
		wdone;
		chk(rd, 32'h0000_0012);
		wb(1'b0, `FSPWG_REG_DATA, 32'h0000_0000);
		chk(rd, 32'h0000_5A3C);
		wb(1'b0, `FSPWG_REG_ADDR, 32'h0000_0000);
		chk(rd, 32'h0000_1234);
		u_fspwg_flash.stuck <= 1'b1;
		u_fspwg_flash.timeoutOn <= 1'b1;
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wdone;
		chk(rd, 32'h0000_0016);
		chk(u_fspwg_flash.cmdHist & 32'h0000_00FF, 32'h0000_00F0);
		u_fspwg_flash.stuck <= 1'b1;
		u_fspwg_flash.abortOn <= 1'b1;
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wdone;
		chk(rd & 32'h0000_0008, 32'h0000_0000);
		chk(u_fspwg_flash.cmdHist & 32'h00FF_FFFF, 32'h00AA_55F0);
		wb(1'b1, `FSPWG_REG_DATA, 32'h0000_1290);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_000D);
		wdone;
		chk(u_fspwg_flash.cmdHist & 32'h0000_00FF, 32'h0000_0090);
		u_fspwg_flash.lockout <= 1'b1;
		fwr(16'h0077);
		chk(u_fspwg_flash.cmdHist & 32'h0000_00FF, 32'h0000_0090);
		u_fspwg_flash.lockout <= 1'b0;
		fwr(16'h00AA);
		fwr(16'h0055);
		fwr(16'h00A0);
		chk(rd, 32'h0000_0012);
		fwr(16'h1234);
		chk(rd, 32'h0000_0002);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wdone;
		chk(rd, 32'h0000_0012);
		u_fspwg_flash.protectOn <= 1'b1;
		fwr(16'h00AA);
		fwr(16'h0055);
		fwr(16'h00A0);
		fwr(16'h1234);
		chk(rd, 32'h0000_0012);
		u_fspwg_flash.protectOn <= 1'b0;
		fwr(16'h00AA);
		fwr(16'h0055);
		fwr(16'h0080);
		fwr(16'h00AA);
		fwr(16'h0055);
		chk(rd, 32'h0000_0012);
		fwr(16'h0030);
		chk(rd, 32'h0000_0002);
		u_fspwg_flash.suspended <= 1'b1;
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wdone;
		chk(rd, 32'h0000_0012);
		u_fspwg_flash.suspended <= 1'b0;
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0009);
		wdone;
		chk(rd, 32'h0000_0012);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_000F);
		wdone;
		chk(u_fspwg_flash.resets, 32'h0000_0001);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0000);
		chk({31'h0, widthSelect}, 32'h0000_0000);
		wb(1'b1, `FSPWG_REG_CTRL, 32'h0000_0003);
		wdone;
		chk(rd, 32'h0000_0012);
		wb(1'b0, `FSPWG_REG_DATA, 32'h0000_0000);
		chk(rd & 32'h0000_00FF, 32'h0000_003C);
		complete_run;
	end
endmodule
